// ==== logic/pahc_pkg.sv ====
package pahc_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [7:0] PAHC_OFS_CTRL    = 8'h00;
    localparam logic [7:0] PAHC_OFS_STATUS  = 8'h04;
    localparam logic [7:0] PAHC_OFS_HOMEPOS = 8'h08;
    localparam logic [7:0] PAHC_OFS_MODE    = 8'h0C;
    localparam logic [7:0] PAHC_OFS_SWSPD   = 8'h10;
    localparam logic [7:0] PAHC_OFS_IDXSPD  = 8'h14;
    localparam logic [7:0] PAHC_OFS_ACCEL   = 8'h18;
    localparam logic [7:0] PAHC_OFS_IRQ_ST  = 8'h1C;
    localparam logic [7:0] PAHC_OFS_IRQ_CLR = 8'h20;
    localparam logic [7:0] PAHC_OFS_IRQ_EN  = 8'h24;
    localparam logic [7:0] PAHC_OFS_CAPPOS  = 8'h28;
    localparam logic [7:0] PAHC_OFS_CAPAXIS = 8'h2C;

    // Control register fields.
    localparam int PAHC_CTRL_START    = 0;
    localparam int PAHC_CTRL_AXIS_LSB = 8;
    localparam int PAHC_AXIS_W        = 4;

    // Status register fields.
    localparam int PAHC_ST_DONE     = 0;
    localparam int PAHC_ST_BUSY     = 1;
    localparam int PAHC_ST_ABORT    = 2;
    localparam int PAHC_ST_FAULT    = 3;
    localparam int PAHC_ST_CODE_LSB = 8;
    localparam int PAHC_ST_AXST_LSB = 16;

    // Interrupt event bit positions.
    localparam int PAHC_IRQ_DONE  = 0;
    localparam int PAHC_IRQ_ABORT = 1;
    localparam int PAHC_IRQ_FAULT = 2;
    localparam int PAHC_IRQ_W     = 3;

    // Reset values of configuration.
    localparam logic [31:0] PAHC_RST_HOMEPOS = 32'h0000_0000;
    localparam logic [7:0]  PAHC_RST_MODE    = 8'h17;
    localparam logic [31:0] PAHC_RST_SWSPD   = 32'h0000_03E8;
    localparam logic [31:0] PAHC_RST_IDXSPD  = 32'h0000_01F4;
    localparam logic [31:0] PAHC_RST_ACCEL   = 32'h0000_07D0;

    // Highest homing method number of the drive profile.
    localparam logic [7:0] PAHC_MODE_MAX = 8'h23;

    typedef enum logic [2:0] {
        PAHC_AX_DISABLED   = 3'b000,
        PAHC_AX_STANDSTILL = 3'b001,
        PAHC_AX_HOMING     = 3'b010,
        PAHC_AX_MOVING     = 3'b011,
        PAHC_AX_STOPPING   = 3'b100,
        PAHC_AX_ERRORSTOP  = 3'b101
    } pahc_axis_state_e;

    typedef enum logic [7:0] {
        PAHC_NO_FAULT      = 8'h00,
        PAHC_FLT_AXIS_BUSY = 8'h01,
        PAHC_FLT_BAD_MODE  = 8'h02,
        PAHC_FLT_NO_TRIG   = 8'h03,
        PAHC_FLT_BAD_SPEED = 8'h04,
        PAHC_FLT_NOT_CFG   = 8'h05
    } pahc_fault_code_e;

endpackage

// ==== logic/pahc_start_check.sv ====
// Decides whether a homing start may proceed and which fault it raises if not.
module pahc_start_check
    import pahc_pkg::*;
(
    input  wire pahc_axis_state_e axis_state,
    input  wire logic             axis_configured,
    input  wire logic [7:0]       homing_mode,
    input  wire logic [31:0]      switch_speed,
    input  wire logic [31:0]      index_speed,
    input  wire logic [31:0]      homing_accel,
    input  wire logic             triggers_assigned,
    output logic                  start_ok,
    output pahc_fault_code_e      start_fault
);

    always_comb begin
        start_ok    = 1'b0;
        start_fault = PAHC_NO_FAULT;
        if (!axis_configured) begin
            start_fault = PAHC_FLT_NOT_CFG;
        end else if (axis_state != PAHC_AX_STANDSTILL) begin
            start_fault = PAHC_FLT_AXIS_BUSY;
        end else if (homing_mode == 8'h00 || homing_mode > PAHC_MODE_MAX) begin
            start_fault = PAHC_FLT_BAD_MODE;
        end else if (switch_speed == 32'h0000_0000 || index_speed == 32'h0000_0000
                     || homing_accel == 32'h0000_0000) begin
            start_fault = PAHC_FLT_BAD_SPEED;
        end else if (!triggers_assigned) begin
            start_fault = PAHC_FLT_NO_TRIG;
        end else begin
            start_ok = 1'b1;
        end
    end

endmodule // pahc_start_check

// ==== logic/pahc_homing_ctrl.sv ====
// Contract
// - A homing run starts only on a rising edge of start_request.
// - Home position and axis handle are captured on an accepted rising edge.
// - homing_done sets on completion; clears on request low or fault.
// - in_progress sets on rising request; clears on completion, stop, fault or falling request.
// - aborted_flag sets on stop; clears on request low, held one cycle.
// - Errors raise fault_flag and code; both clear on request falling.
// - fault_code is an enumeration, no-fault value by default.
// - Starts are accepted only from standstill; otherwise a fault.
// - An accepted start moves the axis from standstill to homing.
// - Homing method is chosen by a configured profile mode number.
// - The axis must be configured; pulses use its mode, speeds, acceleration.
// - Separate switch and index search speeds plus acceleration are configured.
//
// The register addresses and register access over APB are this design's own decisions.
module pahc_homing_ctrl
    import pahc_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   axis_configured,
    input  wire logic                   triggers_assigned,
    input  wire logic                   stop_instruction,
    input  wire logic                   run_complete,
    input  wire logic                   drive_fault,
    output logic                        run_enable,
    output logic [7:0]                  run_mode,
    output logic [31:0]                 run_switch_speed,
    output logic [31:0]                 run_index_speed,
    output logic [31:0]                 run_accel,
    output logic [31:0]                 home_position_value,
    output logic [PAHC_AXIS_W-1:0]      pulse_axis_handle,
    output pahc_axis_state_e            axis_state,
    output logic                        homing_done,
    output logic                        in_progress,
    output logic                        aborted_flag,
    output logic                        fault_flag,
    output pahc_fault_code_e            fault_code,
    output logic                        irq
);

    typedef struct packed {
        logic                     start_request;
        logic                     start_prev;
        logic [PAHC_AXIS_W-1:0]   axis_sel;
        logic [31:0]              homepos;
        logic [7:0]               mode;
        logic [31:0]              swspd;
        logic [31:0]              idxspd;
        logic [31:0]              accel;
        logic [31:0]              cap_pos;
        logic [PAHC_AXIS_W-1:0]   cap_axis;
        pahc_axis_state_e         axst;
        logic                     done;
        logic                     busy;
        logic                     abort;
        logic                     abort_hold;
        logic                     fault;
        pahc_fault_code_e         code;
        logic [PAHC_IRQ_W-1:0]    irq_st;
        logic [PAHC_IRQ_W-1:0]    irq_en;
        logic [31:0]              rdata;
    } pahc_state_s;

    pahc_state_s      st_r;
    pahc_state_s      st_nxt;
    logic             start_ok;
    pahc_fault_code_e start_fault;

    pahc_start_check u_check (
        .axis_state        (st_r.axst),
        .axis_configured   (axis_configured),
        .homing_mode       (st_r.mode),
        .switch_speed      (st_r.swspd),
        .index_speed       (st_r.idxspd),
        .homing_accel      (st_r.accel),
        .triggers_assigned (triggers_assigned),
        .start_ok          (start_ok),
        .start_fault       (start_fault)
    );

    function automatic logic [31:0] read_mux(input pahc_state_s s, input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            PAHC_OFS_CTRL: begin
                v[PAHC_CTRL_START] = s.start_request;
                v[PAHC_CTRL_AXIS_LSB +: PAHC_AXIS_W] = s.axis_sel;
            end
            PAHC_OFS_STATUS: begin
                v[PAHC_ST_DONE]  = s.done;
                v[PAHC_ST_BUSY]  = s.busy;
                v[PAHC_ST_ABORT] = s.abort;
                v[PAHC_ST_FAULT] = s.fault;
                v[PAHC_ST_CODE_LSB +: 8] = s.code;
                v[PAHC_ST_AXST_LSB +: 3] = s.axst;
            end
            PAHC_OFS_HOMEPOS: v = s.homepos;
            PAHC_OFS_MODE:    v[7:0] = s.mode;
            PAHC_OFS_SWSPD:   v = s.swspd;
            PAHC_OFS_IDXSPD:  v = s.idxspd;
            PAHC_OFS_ACCEL:   v = s.accel;
            PAHC_OFS_IRQ_ST:  v[PAHC_IRQ_W-1:0] = s.irq_st;
            PAHC_OFS_IRQ_EN:  v[PAHC_IRQ_W-1:0] = s.irq_en;
            PAHC_OFS_CAPPOS:  v = s.cap_pos;
            PAHC_OFS_CAPAXIS: v[PAHC_AXIS_W-1:0] = s.cap_axis;
            default:          v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    function automatic logic addr_known(input logic [7:0] a);
        return (a <= PAHC_OFS_CAPAXIS) && (a[1:0] == 2'b00);
    endfunction

    logic bus_access;
    logic bus_wr;
    logic rise;
    logic fall;
    logic [PAHC_IRQ_W-1:0] ev;

    assign bus_access = psel && penable;
    assign bus_wr     = bus_access && pwrite && addr_known(paddr);
    assign rise       = st_r.start_request && !st_r.start_prev;
    assign fall       = !st_r.start_request && st_r.start_prev;

    always_comb begin
        st_nxt = st_r;
        ev     = '0;
        st_nxt.start_prev = st_r.start_request;

        // Software writes; the start bit is a level that software raises and drops.
        if (bus_wr) begin
            case (paddr)
                PAHC_OFS_CTRL: begin
                    st_nxt.start_request = pwdata[PAHC_CTRL_START];
                    st_nxt.axis_sel      = pwdata[PAHC_CTRL_AXIS_LSB +: PAHC_AXIS_W];
                end
                PAHC_OFS_HOMEPOS: st_nxt.homepos = pwdata;
                PAHC_OFS_MODE:    st_nxt.mode    = pwdata[7:0];
                PAHC_OFS_SWSPD:   st_nxt.swspd   = pwdata;
                PAHC_OFS_IDXSPD:  st_nxt.idxspd  = pwdata;
                PAHC_OFS_ACCEL:   st_nxt.accel   = pwdata;
                PAHC_OFS_IRQ_CLR: st_nxt.irq_st  = st_r.irq_st & ~pwdata[PAHC_IRQ_W-1:0];
                PAHC_OFS_IRQ_EN:  st_nxt.irq_en  = pwdata[PAHC_IRQ_W-1:0];
                default: begin
                end
            endcase
        end

        // A falling request clears the done, busy, abort and fault flags and the recorded code; interrupt status is kept.
        if (fall) begin
            st_nxt.done  = 1'b0;
            st_nxt.busy  = 1'b0;
            st_nxt.abort = 1'b0;
            st_nxt.fault = 1'b0;
            st_nxt.code  = PAHC_NO_FAULT;
            st_nxt.abort_hold = 1'b0;
        end

        // An abort raised with the request already low lives for one cycle only.
        if (st_r.abort && !st_r.start_request && !fall) begin
            if (st_r.abort_hold) begin
                st_nxt.abort_hold = 1'b0;
            end else begin
                st_nxt.abort = 1'b0;
            end
        end

        if (rise && !st_r.busy) begin
            if (start_ok) begin
                st_nxt.busy     = 1'b1;
                st_nxt.done     = 1'b0;
                st_nxt.abort    = 1'b0;
                st_nxt.cap_pos  = st_r.homepos;
                st_nxt.cap_axis = st_r.axis_sel;
                st_nxt.axst     = PAHC_AX_HOMING;
            end else begin
                st_nxt.fault = 1'b1;
                st_nxt.code  = start_fault;
                ev[PAHC_IRQ_FAULT] = 1'b1;
            end
        end else if (st_r.busy) begin
            if (drive_fault) begin
                st_nxt.busy  = 1'b0;
                st_nxt.done  = 1'b0;
                st_nxt.fault = 1'b1;
                st_nxt.code  = PAHC_FLT_NOT_CFG;
                st_nxt.axst  = PAHC_AX_ERRORSTOP;
                ev[PAHC_IRQ_FAULT] = 1'b1;
            end else if (stop_instruction) begin
                st_nxt.busy       = 1'b0;
                st_nxt.abort      = 1'b1;
                st_nxt.abort_hold = st_r.start_request;
                st_nxt.axst       = PAHC_AX_STOPPING;
                ev[PAHC_IRQ_ABORT] = 1'b1;
            end else if (run_complete) begin
                st_nxt.busy = 1'b0;
                // A request dropped in this very cycle still sees done for one cycle.
                st_nxt.done = 1'b1;
                st_nxt.axst = PAHC_AX_STANDSTILL;
                ev[PAHC_IRQ_DONE] = 1'b1;
            end
        end else if (st_r.axst == PAHC_AX_STOPPING) begin
            st_nxt.axst = PAHC_AX_STANDSTILL;
        end

        // Done with the request already low lasts a single cycle.
        if (st_r.done && !st_r.start_request && !fall && !ev[PAHC_IRQ_DONE]) begin
            st_nxt.done = 1'b0;
        end

        // Event setting wins over a same-cycle software clear.
        st_nxt.irq_st = st_nxt.irq_st | ev;
        st_nxt.rdata  = read_mux(st_r, paddr);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r         <= '0;
            st_r.homepos <= PAHC_RST_HOMEPOS;
            st_r.mode    <= PAHC_RST_MODE;
            st_r.swspd   <= PAHC_RST_SWSPD;
            st_r.idxspd  <= PAHC_RST_IDXSPD;
            st_r.accel   <= PAHC_RST_ACCEL;
            st_r.axst    <= PAHC_AX_STANDSTILL;
            st_r.code    <= PAHC_NO_FAULT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Read data is registered in the setup cycle, so every access completes at once.
    assign prdata              = st_r.rdata;
    assign pready              = 1'b1;
    assign pslverr             = bus_access && !addr_known(paddr);
    assign run_enable          = st_r.busy;
    assign run_mode            = st_r.mode;
    assign run_switch_speed    = st_r.swspd;
    assign run_index_speed     = st_r.idxspd;
    assign run_accel           = st_r.accel;
    assign home_position_value = st_r.cap_pos;
    assign pulse_axis_handle   = st_r.cap_axis;
    assign axis_state          = st_r.axst;
    assign homing_done         = st_r.done;
    assign in_progress         = st_r.busy;
    assign aborted_flag        = st_r.abort;
    assign fault_flag          = st_r.fault;
    assign fault_code          = st_r.code;
    assign irq                 = |(st_r.irq_st & st_r.irq_en);

endmodule // pahc_homing_ctrl

// ==== tb/pahc_drive_model.sv ====
// Stand-in for the pulse drive: raises run_complete run_cycles + 1 cycles after run_enable rises.
module pahc_drive_model
    import pahc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        run_enable,
    input  wire logic [7:0]  run_mode,
    input  wire logic [31:0] run_switch_speed,
    input  wire logic [31:0] run_index_speed,
    input  wire logic [31:0] run_accel,
    input  wire logic [7:0]  run_cycles,
    output logic             run_complete
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt_r;
    logic       cfg_ok;
    // A drive given a zero rate or no method would never arrive, so it never reports done.
    assign cfg_ok = (run_mode != 8'h00) && (run_switch_speed != 32'h0000_0000)
        && (run_index_speed != 32'h0000_0000) && (run_accel != 32'h0000_0000);
    always_ff @(posedge core_clk) begin
        if (reset || !run_enable) begin
            cnt_r <= 8'h00;
            run_complete <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 8'h01;
            run_complete <= cfg_ok && (cnt_r == run_cycles);
        end
    end
endmodule // pahc_drive_model

// ==== tb/pahc_homing_ctrl_assertions.sv ====
module pahc_hc_checker
    import pahc_pkg::*;
(
    input wire logic                   core_clk,
    input wire logic                   reset,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic [7:0]             paddr,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   run_enable,
    input wire logic [31:0]            home_position_value,
    input wire logic [PAHC_AXIS_W-1:0] pulse_axis_handle,
    input wire pahc_axis_state_e       axis_state,
    input wire logic                   homing_done,
    input wire logic                   in_progress,
    input wire logic                   fault_flag,
    input wire pahc_fault_code_e       fault_code
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    a_fault_busy_excl: assert property (fault_flag |-> !in_progress)
        else $error("busy while faulted");
    a_done_ends_run: assert property ($rose(homing_done) |->
        !in_progress && axis_state == PAHC_AX_STANDSTILL) else $error("done with run open");
    a_done_no_fault: assert property (homing_done |-> !fault_flag)
        else $error("done beside fault");
    a_code_idle_none: assert property (!fault_flag |-> fault_code == PAHC_NO_FAULT)
        else $error("stale fault code");
    a_code_on_fault: assert property (fault_flag |-> fault_code != PAHC_NO_FAULT)
        else $error("fault without code");
    a_capture_held: assert property (in_progress && $past(in_progress) |->
        $stable(home_position_value) && $stable(pulse_axis_handle)) else $error("capture moved");
    a_start_homing: assert property ($rose(in_progress) |->
        axis_state == PAHC_AX_HOMING && $past(axis_state) == PAHC_AX_STANDSTILL)
        else $error("bad start state");
    a_run_follows: assert property (run_enable == in_progress)
        else $error("drive enable differs from busy");
    a_apb_answer: assert property (psel && penable |-> pready
        && pslverr == (paddr > PAHC_OFS_CAPAXIS || paddr[1:0] != 2'b00))
        else $error("bad apb response");
endmodule // pahc_hc_checker

bind pahc_homing_ctrl pahc_hc_checker i_chk (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .run_enable(run_enable),
    .home_position_value(home_position_value), .pulse_axis_handle(pulse_axis_handle),
    .axis_state(axis_state), .homing_done(homing_done), .in_progress(in_progress),
    .fault_flag(fault_flag), .fault_code(fault_code)
);

// ==== tb/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pahc_pkg::*;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, run_enable, irq;
    logic axis_configured, triggers_assigned, stop_instruction, run_complete, drive_fault;
    logic homing_done, in_progress, aborted_flag, fault_flag;
    logic [7:0] paddr, run_mode, run_cycles;
    logic [31:0] pwdata, prdata, rd, run_switch_speed, run_index_speed, run_accel;
    logic [31:0] home_position_value;
    logic [PAHC_AXIS_W-1:0] pulse_axis_handle;
    logic [3:0] fl;
    pahc_axis_state_e axis_state;
    pahc_fault_code_e fault_code;
    int n_fail = 0;
    int cmp_count = 0;
    typedef struct {logic [7:0] a; logic [31:0] e;} pahc_row_s;
    pahc_row_s rows [10] = '{'{PAHC_OFS_STATUS, 32'h0001_0000}, '{PAHC_OFS_CTRL, 32'h0000_0000},
        '{PAHC_OFS_HOMEPOS, 32'h0000_0000}, '{PAHC_OFS_MODE, 32'h0000_0017},
        '{PAHC_OFS_SWSPD, 32'h0000_03E8}, '{PAHC_OFS_IDXSPD, 32'h0000_01F4},
        '{PAHC_OFS_ACCEL, 32'h0000_07D0}, '{PAHC_OFS_IRQ_ST, 32'h0000_0000},
        '{PAHC_OFS_IRQ_CLR, 32'h0000_0000}, '{8'h30, 32'h0000_0000}};
    assign fl = {fault_flag, aborted_flag, in_progress, homing_done};

    pahc_homing_ctrl i_dut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .axis_configured(axis_configured),
        .triggers_assigned(triggers_assigned), .stop_instruction(stop_instruction),
        .run_complete(run_complete), .drive_fault(drive_fault),
        .run_enable(run_enable), .run_mode(run_mode), .run_switch_speed(run_switch_speed),
        .run_index_speed(run_index_speed), .run_accel(run_accel),
        .home_position_value(home_position_value), .pulse_axis_handle(pulse_axis_handle),
        .axis_state(axis_state), .homing_done(homing_done), .in_progress(in_progress),
        .aborted_flag(aborted_flag), .fault_flag(fault_flag), .fault_code(fault_code), .irq(irq));
    pahc_drive_model i_drv (.core_clk(core_clk), .reset(reset), .run_enable(run_enable),
        .run_mode(run_mode), .run_switch_speed(run_switch_speed),
        .run_index_speed(run_index_speed), .run_accel(run_accel), .run_cycles(run_cycles),
        .run_complete(run_complete));

    always #2.5 core_clk = ~core_clk;

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        n_fail++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        cmp_count++;
        if (g !== e) fail(m);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            fail("bus hang");
            final_report();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wait_bit(input int k, input logic v);
        int n;
        n = 0;
        while (fl[k] !== v && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        if (fl[k] !== v) begin
            fail("flag wait");
            final_report();
        end
    endtask
    // Each refused start must leave the axis idle and clear fully on request drop.
    task automatic fault_case(input logic [7:0] md, input logic cfg, input logic trg,
                              input pahc_fault_code_e e);
        apb(1'b1, PAHC_OFS_MODE, {24'h00_0000, md});
        axis_configured <= cfg;
        triggers_assigned <= trg;
        apb(1'b1, PAHC_OFS_CTRL, 32'h0000_0001);
        wait_bit(3, 1'b1);
        chk(in_progress, 32'h0000_0000, "busy on refused start");
        chk(fault_code, e, "fault code");
        apb(1'b1, PAHC_OFS_CTRL, 32'h0000_0000);
        wait_bit(3, 1'b0);
        chk(fault_code, PAHC_NO_FAULT, "code kept");
        axis_configured <= 1'b1;
        triggers_assigned <= 1'b1;
        apb(1'b1, PAHC_OFS_MODE, 32'h0000_0017);
        $display("test fault %0d done", e);
    endtask

    initial begin
        core_clk = 1'b0;
        reset = 1'b1;
        {psel, penable, pwrite, stop_instruction, drive_fault} = 5'b0_0000;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        axis_configured = 1'b1;
        triggers_assigned = 1'b1;
        run_cycles = 8'h14;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0000_0000);
            chk(rd, rows[i].e, "register default");
        end
        $display("test defaults done");
        apb(1'b1, PAHC_OFS_IRQ_EN, 32'h0000_0007);
        apb(1'b1, PAHC_OFS_HOMEPOS, 32'hFFFF_FFFB);
        apb(1'b1, PAHC_OFS_CTRL, 32'h0000_0301);
        wait_bit(1, 1'b1);
        chk(home_position_value, 32'hFFFF_FFFB, "captured position");
        chk(axis_state, PAHC_AX_HOMING, "state on start");
        apb(1'b1, PAHC_OFS_HOMEPOS, 32'h0000_0009);
        apb(1'b1, PAHC_OFS_CTRL, 32'h0000_0501);
        // Let a wrongly detected edge reach the outputs before looking.
        repeat (2) @(posedge core_clk);
        chk(pulse_axis_handle, 32'h0000_0003, "axis recaptured");
        chk(home_position_value, 32'hFFFF_FFFB, "position recaptured");
        wait_bit(0, 1'b1);
        chk(axis_state, PAHC_AX_STANDSTILL, "state after run");
        chk(irq, 32'h0000_0001, "done interrupt");
        apb(1'b1, PAHC_OFS_IRQ_CLR, 32'h0000_0001);
        chk(irq, 32'h0000_0000, "interrupt not cleared");
        apb(1'b1, PAHC_OFS_CTRL, 32'h0000_0501);
        repeat (2) @(posedge core_clk);
        chk(in_progress, 32'h0000_0000, "restart on held level");
        apb(1'b1, PAHC_OFS_CTRL, 32'h0000_0000);
        wait_bit(0, 1'b0);
        $display("test run done");
        apb(1'b1, PAHC_OFS_IRQ_EN, 32'h0000_0003);
        fault_case(8'h17, 1'b1, 1'b0, PAHC_FLT_NO_TRIG);
        fault_case(8'h00, 1'b1, 1'b1, PAHC_FLT_BAD_MODE);
        fault_case(8'h24, 1'b1, 1'b1, PAHC_FLT_BAD_MODE);
        fault_case(8'h17, 1'b0, 1'b1, PAHC_FLT_NOT_CFG);
        apb(1'b1, PAHC_OFS_SWSPD, 32'h0000_0000);
        fault_case(8'h17, 1'b1, 1'b1, PAHC_FLT_BAD_SPEED);
        apb(1'b1, PAHC_OFS_SWSPD, PAHC_RST_SWSPD);
        chk(irq, 32'h0000_0000, "masked fault interrupt");
        apb(1'b0, PAHC_OFS_IRQ_ST, 32'h0000_0000);
        chk(rd, 32'h0000_0004, "fault event");
        run_cycles <= 8'hC8;
        apb(1'b1, PAHC_OFS_CTRL, 32'h0000_0001);
        wait_bit(1, 1'b1);
        stop_instruction <= 1'b1;
        @(posedge core_clk);
        stop_instruction <= 1'b0;
        wait_bit(2, 1'b1);
        chk(irq, 32'h0000_0001, "abort interrupt");
        apb(1'b1, PAHC_OFS_CTRL, 32'h0000_0000);
        wait_bit(2, 1'b0);
        $display("test abort done");
        repeat (4) @(posedge core_clk);
        apb(1'b1, PAHC_OFS_CTRL, 32'h0000_0001);
        wait_bit(1, 1'b1);
        drive_fault <= 1'b1;
        @(posedge core_clk);
        drive_fault <= 1'b0;
        wait_bit(3, 1'b1);
        chk(in_progress, 32'h0000_0000, "busy after drive fault");
        chk(fault_code, PAHC_FLT_NOT_CFG, "drive fault code");
        apb(1'b1, PAHC_OFS_CTRL, 32'h0000_0000);
        wait_bit(3, 1'b0);
        $display("test drive fault done");
        // The axis is left in error stop, so a new start must be refused.
        fault_case(8'h17, 1'b1, 1'b1, PAHC_FLT_AXIS_BUSY);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        chk(axis_state, PAHC_AX_STANDSTILL, "state after reset");
        apb(1'b1, PAHC_OFS_CTRL, 32'h0000_0001);
        wait_bit(1, 1'b1);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        chk(fl, 32'h0000_0000, "flags after reset");
        chk(home_position_value, 32'h0000_0000, "position after reset");
        apb(1'b1, PAHC_OFS_CTRL, 32'h0000_0001);
        wait_bit(1, 1'b1);
        $display("test reset done");
        final_report();
    end
endmodule // tb
